// ==== design/lec_consts.svh ====
/*
 * constants of the link enhancement control block: offset, fields,
 * reset value, write mask and threshold byte counts.
 * assumes inclusion by bare name from the block's modules.
 */
`ifndef LEC_CONSTS_SVH
`define LEC_CONSTS_SVH

// register offset in configuration space
`define LEC_REG_OFFSET 8'hF4
// reset value and mask of writable bits
`define LEC_REG_RESET 32'h0000_1000
`define LEC_WR_MASK 32'h0000_3086
// field positions
`define LEC_THR_HI 13
`define LEC_THR_LO 12
`define LEC_PRIO_BIT 7
`define LEC_UNASSIGNED_BIT 6
`define LEC_IDLE_BIT 2
`define LEC_ACCEL_BIT 1
// start levels in bytes, per encoding
`define LEC_THR_SF_BYTES 12'h800
`define LEC_THR_1P7K_BYTES 12'h6CC
`define LEC_THR_1K_BYTES 12'h400
`define LEC_THR_512_BYTES 12'h200
// bytes moved by one fifo push (one quadlet)
`define LEC_PUSH_BYTES 12'h004
// turnaround cycles when idle insertion is on
`define LEC_TURN_CYCLES 1

`endif

// ==== design/lec_pkg.sv ====
/*
 * types of the link enhancement control block.
 * assumes lec_consts.svh carries every number.
 */
package lec_pkg;

    // start level encodings of the threshold field
    typedef enum logic [1:0] {
        LEC_THR_SF = 2'h0,
        LEC_THR_1P7K = 2'h1,
        LEC_THR_1K = 2'h2,
        LEC_THR_512 = 2'h3
    } lec_thr_t;

    // decoded control bits as stored
    typedef struct packed {
        lec_thr_t thr;
        logic prio;
        logic idle;
        logic accel;
    } lec_ctrl_t;

    // configuration access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } lec_cfg_req_t;

    // transmit sequencer states
    typedef enum logic [1:0] {
        LEC_ST_FILL = 2'h0,
        LEC_ST_SEND = 2'h1,
        LEC_ST_RETRY = 2'h2
    } lec_state_t;

endpackage

// ==== design/lec_regfile.sv ====
/*
 * storage of the link enhancement control word with config access
 * and serial eeprom load.
 * assumes requests and load strobes come from the same clock domain.
 */
`timescale 1ns/100ps
`include "lec_consts.svh"

module lec_regfile (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // config access
    input wire lec_pkg::lec_cfg_req_t cfg_i,
    output logic [31:0] cfg_rdata_o,
    // eeprom load
    input wire logic ee_load_i,
    input wire logic [31:0] ee_data_i,
    // stored controls and bit 6 redirect
    output lec_pkg::lec_ctrl_t ctrl_o,
    output logic ee_prog_phy_o,
    output logic ee_prog_phy_vld_o
);

    logic [31:0] reg_r; // only writable bits ever set
    logic [31:0] be_mask_w; // byte lanes enabled
    logic hit_w; // address match
    logic [31:0] reg_nxt;
    logic ee_prog_r;
    logic ee_vld_r;

    assign hit_w = (cfg_i.addr == `LEC_REG_OFFSET);
    assign be_mask_w = {{8{cfg_i.be[3]}}, {8{cfg_i.be[2]}},
                        {8{cfg_i.be[1]}}, {8{cfg_i.be[0]}}};
    // eeprom load beats a config write in the same cycle
    assign reg_nxt = ee_load_i ? (ee_data_i & `LEC_WR_MASK) : // [R2]
                     (cfg_i.wr && hit_w) ?
                     ((reg_r & ~be_mask_w) | (cfg_i.wdata & be_mask_w & `LEC_WR_MASK)) :
                     reg_r; // reserved bits stay zero [R10] [R11] [R15]

    ////////////////////////////////////////////////////////////////////////
    // register and read data
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_r <= `LEC_REG_RESET;
            cfg_rdata_o <= 32'h0000_0000;
            ee_prog_r <= 1'b0;
            ee_vld_r <= 1'b0;
        end else begin
            reg_r <= reg_nxt;
            cfg_rdata_o <= (cfg_i.rd && hit_w) ? reg_r : 32'h0000_0000;
            ee_vld_r <= ee_load_i;
            // bit 6 of the eeprom image goes elsewhere [R11]
            if (ee_load_i) begin
                ee_prog_r <= ee_data_i[`LEC_UNASSIGNED_BIT];
            end
        end
    end

    assign ctrl_o.thr = lec_pkg::lec_thr_t'(reg_r[`LEC_THR_HI:`LEC_THR_LO]); // [R3]
    assign ctrl_o.prio = reg_r[`LEC_PRIO_BIT];
    assign ctrl_o.idle = reg_r[`LEC_IDLE_BIT];
    assign ctrl_o.accel = reg_r[`LEC_ACCEL_BIT];
    assign ee_prog_phy_o = ee_prog_r;
    assign ee_prog_phy_vld_o = ee_vld_r;

endmodule

// ==== design/lec_thresh.sv ====
/*
 * start level decode and the start decision for a packet.
 * assumes byte count and end-of-packet flag are per packet.
 */
`timescale 1ns/100ps
`include "lec_consts.svh"

module lec_thresh (
    // settings
    input wire lec_pkg::lec_thr_t thr_i,
    input wire logic force_sf_i,
    // packet fill state
    input wire logic [11:0] byte_cnt_i,
    input wire logic eop_seen_i,
    // decision
    output logic sf_mode_o,
    output logic start_ok_o
);

    // byte level for one encoding
    function automatic logic [11:0] lec_level(input lec_pkg::lec_thr_t t);
        case (t)
            lec_pkg::LEC_THR_SF: lec_level = `LEC_THR_SF_BYTES;
            lec_pkg::LEC_THR_1P7K: lec_level = `LEC_THR_1P7K_BYTES;
            lec_pkg::LEC_THR_1K: lec_level = `LEC_THR_1K_BYTES;
            lec_pkg::LEC_THR_512: lec_level = `LEC_THR_512_BYTES;
            default: lec_level = `LEC_THR_SF_BYTES;
        endcase
    endfunction

    logic [11:0] level_w; // selected start level
    logic level_hit_w;

    assign level_w = lec_level(thr_i); // [R3]
    // 2K encoding or a forcing cause means complete packets only [R7]
    assign sf_mode_o = force_sf_i || (thr_i == lec_pkg::LEC_THR_SF);
    assign level_hit_w = (byte_cnt_i >= level_w); // [R16]
    // level reached, or whole packet already inside [R5]
    assign start_ok_o = eop_seen_i || (!sf_mode_o && level_hit_w);

endmodule

// ==== design/lec_top.sv ====
/*
 * link enhancement control: register, async transmit start control
 * with underrun fallback, and phy facing enhancement outputs.
 * assumes one clock for config, fifo status and phy pins; fifo
 * status comes from logic on this clock, phy control lines from pins.
 */
// What this block does
// R1 - enhancement bits act only with gate set
// R2 - software write or eeprom load initializes
// R3 - decode start field: 2K,1.7K,1K,512
// R4 - retry after underrun uses store-and-forward
// R5 - start at level or on complete packet
// R6 - fifo drained before packet end: underrun
// R7 - 2K setting sends only complete packets
// R8 - retries register zero forces store-and-forward
// R9 - bit 7 enables priority arbitration responses
// R10 - reserved ranges read zero, read-only
// R11 - bit 6 unassigned; eeprom bit redirected
// R12 - software should keep 1.7K start level
// R13 - bit 2 inserts one turnaround cycle
// R14 - bit 1 announces acceleration to phy
// R15 - bit 0 read-only, reads zero
// R16 - compare per-packet byte count to level
`timescale 1ns/100ps
`include "lec_consts.svh"

module lec_top (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // configuration access
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    // serial eeprom loader
    input wire logic ee_load_i,
    input wire logic [31:0] ee_data_i,
    output logic ee_prog_phy_o,
    output logic ee_prog_phy_vld_o,
    // host controller state
    input wire logic phy_enhance_gate_i,
    input wire logic retries_zero_i,
    // async transmit fifo status
    input wire logic at_push_i,
    input wire logic at_eop_i,
    input wire logic at_empty_i,
    input wire logic at_tx_done_i,
    // async transmit control
    output logic at_tx_start_o,
    output logic at_underrun_o,
    output logic at_sf_mode_o,
    // phy side
    input wire logic [1:0] phy_ctl_i,
    input wire logic link_req_i,
    output logic link_drive_o,
    output logic prio_arb_en_o,
    output logic accel_en_o
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    // _w names are combinational nets, _r names are flops and _nxt names
    // are the values those flops take at the next edge

    lec_pkg::lec_cfg_req_t cfg_w; // bundled request
    lec_pkg::lec_ctrl_t ctrl_w; // stored controls
    lec_pkg::lec_thr_t thr_eff_w; // threshold after gating
    lec_pkg::lec_state_t state_r; // sequencer state
    lec_pkg::lec_state_t state_nxt;
    logic [11:0] cnt_r; // bytes of current packet
    logic [11:0] cnt_nxt;
    logic [11:0] cnt_sum_w; // count plus one push
    logic eop_r; // end token inside fifo
    logic eop_nxt;
    logic retry_r; // packet being retried
    logic retry_nxt;
    logic force_sf_w; // store-and-forward forced
    logic sf_mode_w;
    logic start_ok_w;
    logic start_w; // start pulse this cycle
    logic underrun_w; // drained early this cycle
    logic start_r;
    logic underrun_r;
    logic [1:0] ctl_m_r; // first sync stage
    logic [1:0] ctl_s_r; // second sync stage
    logic grant_w; // phy handed lines back
    logic own_r; // link holds the lines
    logic idle_eff_w;
    logic prio_r;
    logic accel_r;
    logic sf_r;

    ////////////////////////////////////////////////////////////////////////
    // register storage
    // the word itself lives in the register file; this level only
    // bundles the request so the file sees one carrier struct

    assign cfg_w.wr = cfg_wr_i;
    assign cfg_w.rd = cfg_rd_i;
    assign cfg_w.addr = cfg_addr_i;
    assign cfg_w.be = cfg_be_i;
    assign cfg_w.wdata = cfg_wdata_i;

    // writes from software or eeprom, masked readback
    lec_regfile u_regfile (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .cfg_i(cfg_w),
        .cfg_rdata_o(cfg_rdata_o),
        .ee_load_i(ee_load_i),
        .ee_data_i(ee_data_i),
        .ctrl_o(ctrl_w),
        .ee_prog_phy_o(ee_prog_phy_o),
        .ee_prog_phy_vld_o(ee_prog_phy_vld_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // start level selection
    // the gate is a level from the host control register on this clock,
    // so it is used directly with no synchroniser

    // without the gate the field is ignored and the safe mode rules
    assign thr_eff_w = phy_enhance_gate_i ? ctrl_w.thr
                                          : lec_pkg::LEC_THR_SF; // [R1]
    // retry fallback and zero retries both force complete packets
    assign force_sf_w = retry_r || retries_zero_i; // [R4] [R8]

    lec_thresh u_thresh (
        .thr_i(thr_eff_w),
        .force_sf_i(force_sf_w),
        .byte_cnt_i(cnt_r),
        .eop_seen_i(eop_r),
        .sf_mode_o(sf_mode_w),
        .start_ok_o(start_ok_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // per-packet fill tracking
    // one push is one quadlet; the count is cleared when a packet leaves
    // or is abandoned after an underrun

    // saturate so a huge packet cannot wrap below the level
    assign cnt_sum_w = (cnt_r > (12'hFFF - `LEC_PUSH_BYTES)) ? 12'hFFF
                     : cnt_r + `LEC_PUSH_BYTES; // [R16]

    ////////////////////////////////////////////////////////////////////////
    // transmit sequencer decisions
    // an underrun is only possible while sending a packet that was
    // started before its end token arrived

    // early drain: empty while packet end is still outside
    assign underrun_w = (state_r == lec_pkg::LEC_ST_SEND) && at_empty_i &&
                        !eop_r && !at_push_i && !at_tx_done_i; // [R6]
    // start from fill on level or complete packet
    assign start_w = ((state_r == lec_pkg::LEC_ST_FILL) && start_ok_w) ||
                     ((state_r == lec_pkg::LEC_ST_RETRY) && eop_r); // [R4] [R5] [R7]

    // next state, count, end flag and retry flag
    // fill: gather data until the start decision
    // send: packet on the wire until done or an early drain
    // retry: the failed packet is fetched again, sent only when whole
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = at_push_i ? cnt_sum_w : cnt_r;
        eop_nxt = eop_r || (at_push_i && at_eop_i);
        retry_nxt = retry_r;
        case (state_r)
            lec_pkg::LEC_ST_FILL: begin
                // wait for the level or the whole packet
                if (start_w) begin
                    state_nxt = lec_pkg::LEC_ST_SEND;
                end
            end
            lec_pkg::LEC_ST_SEND: begin
                if (at_tx_done_i) begin
                    // packet gone: new packet restarts count [R16]
                    state_nxt = lec_pkg::LEC_ST_FILL;
                    cnt_nxt = 12'h000;
                    eop_nxt = 1'b0;
                    retry_nxt = 1'b0;
                end else if (underrun_w) begin
                    // packet will be refetched whole for the retry
                    state_nxt = lec_pkg::LEC_ST_RETRY;
                    cnt_nxt = 12'h000;
                    eop_nxt = 1'b0;
                    retry_nxt = 1'b1; // [R4]
                end
            end
            lec_pkg::LEC_ST_RETRY: begin
                // resend only once the complete packet is in
                if (start_w) begin
                    state_nxt = lec_pkg::LEC_ST_SEND;
                end
            end
            default: begin
                state_nxt = lec_pkg::LEC_ST_FILL;
                cnt_nxt = 12'h000;
                eop_nxt = 1'b0;
                retry_nxt = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer registers
    // reset lands in fill with an empty count and no retry pending;
    // count and end flag always clear together; the retry flag clears with them except on an underrun, where it sets

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= lec_pkg::LEC_ST_FILL;
            cnt_r <= 12'h000;
            eop_r <= 1'b0;
            retry_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            eop_r <= eop_nxt;
            retry_r <= retry_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit outputs, one cycle after the decision
    // registering costs a cycle of latency but keeps the pulses glitch
    // free toward the transmit engine; sf mode resets high, the safe side

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_r <= 1'b0;
            underrun_r <= 1'b0;
            sf_r <= 1'b1;
        end else begin
            start_r <= start_w;
            underrun_r <= underrun_w; // [R6]
            sf_r <= sf_mode_w;
        end
    end

    assign at_tx_start_o = start_r;
    assign at_underrun_o = underrun_r;
    assign at_sf_mode_o = sf_r;

    ////////////////////////////////////////////////////////////////////////
    // phy control line synchroniser
    // the first stage may go metastable; nothing else may look at it,
    // only the second stage is read by the logic below

    // pins may be skewed against our clock: two stages first
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl_m_r <= 2'h0;
            ctl_s_r <= 2'h0;
        end else begin
            ctl_m_r <= phy_ctl_i;
            ctl_s_r <= ctl_m_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line ownership and turnaround
    // the link only ever drives while it still requests; dropping the
    // request releases the lines in the same cycle, before own_r clears

    // phy drives 11 on the control lines to hand them over
    assign grant_w = link_req_i && (ctl_s_r == 2'h3);
    assign idle_eff_w = ctrl_w.idle && phy_enhance_gate_i; // [R1]

    // ownership held while the link keeps requesting
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            own_r <= 1'b0;
        end else begin
            own_r <= link_req_i && (own_r || grant_w);
        end
    end

    // idle insertion delays the first drive by one cycle [R13]
    // a request already dropped must not keep the lines for one more cycle
    assign link_drive_o = link_req_i && (own_r || (grant_w && !idle_eff_w)); // [R13]

    ////////////////////////////////////////////////////////////////////////
    // phy enhancement announcements
    // both flags are registered so the phy sees clean levels, and both
    // fall with the gate even if software left the bits set

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prio_r <= 1'b0;
            accel_r <= 1'b0;
        end else begin
            prio_r <= ctrl_w.prio && phy_enhance_gate_i; // [R9] [R1]
            accel_r <= ctrl_w.accel && phy_enhance_gate_i; // [R14] [R1]
        end
    end

    assign prio_arb_en_o = prio_r;
    assign accel_en_o = accel_r;

endmodule

// ==== bench/lec_top_props.sv ====
/*
 * port checker of the link enhancement control block.
 * assumes one clock and an asynchronous active low reset on lec_top.
 */
`timescale 1ns/100ps
module lec_top_props (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // config and eeprom
    input wire logic cfg_rd_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic ee_load_i,
    input wire logic ee_prog_phy_vld_o,
    // host state and fifo
    input wire logic phy_enhance_gate_i,
    input wire logic retries_zero_i,
    input wire logic at_push_i,
    input wire logic at_empty_i,
    input wire logic at_tx_done_i,
    input wire logic at_tx_start_o,
    input wire logic at_underrun_o,
    input wire logic at_sf_mode_o,
    // phy side
    input wire logic [1:0] phy_ctl_i,
    input wire logic link_req_i,
    input wire logic link_drive_o,
    input wire logic prio_arb_en_o,
    input wire logic accel_en_o
);
    // one domain, so one clock and one disable for all
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////
    a_rsvd_read_zero: assert property ((cfg_rdata_o & 32'hFFFF_CF79) == 32'h0)
        else $error("reserved bits read nonzero");
    a_rdata_idle: assert property (!cfg_rd_i |=> cfg_rdata_o == 32'h0)
        else $error("read data without read");
    a_prio_gated: assert property (prio_arb_en_o |-> $past(phy_enhance_gate_i))
        else $error("priority enable without gate");
    a_accel_gated: assert property (accel_en_o |-> $past(phy_enhance_gate_i))
        else $error("accel enable without gate");
    a_sf_retries: assert property (retries_zero_i [*2] |-> at_sf_mode_o)
        else $error("no store-and-forward with zero retries");
    a_sf_gate_off: assert property (!phy_enhance_gate_i [*2] |-> at_sf_mode_o)
        else $error("no store-and-forward with gate off");
    a_start_single: assert property (at_tx_start_o |=> !at_tx_start_o)
        else $error("start pulse too long");
    a_underrun_cause: assert property (at_underrun_o |->
        $past(at_empty_i && !at_push_i && !at_tx_done_i))
        else $error("underrun without empty fifo");
    a_ee_valid: assert property (ee_load_i |=> ee_prog_phy_vld_o)
        else $error("eeprom valid missing");
    a_drive_req: assert property (link_drive_o |-> link_req_i)
        else $error("drive without request");
    a_drive_grant: assert property ($rose(link_drive_o) |->
        $past(phy_ctl_i, 1) == 2'h3
        || $past(phy_ctl_i, 2) == 2'h3 || $past(phy_ctl_i, 3) == 2'h3)
        else $error("drive without phy grant");
    // main scenarios reached
    c_start: cover property (at_tx_start_o);
    c_underrun: cover property (at_underrun_o);
    c_drive: cover property ($rose(link_drive_o));
endmodule
bind lec_top lec_top_props i_lec_top_props (.*);

// ==== bench/lec_phy_model.sv ====
/*
 * phy side of the link control lines.
 * assumes the bench says when the phy hands the lines over.
 */
`timescale 1ns/100ps
module lec_phy_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // bench control
    input wire logic give_i,
    // phy control pins
    output logic [1:0] phy_ctl_o
);
    // grant with 11; otherwise churn 01/10 so no stale grant lingers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phy_ctl_o <= 2'h1;
        end else if (give_i) begin
            phy_ctl_o <= 2'h3;
        end else begin
            phy_ctl_o <= {phy_ctl_o[0], ~phy_ctl_o[0]};
        end
    end
endmodule

// ==== bench/tb_top.sv ====
/*
 * self-checking bench of lec_top with a register model and fifo stimulus.
 * assumes lec_consts.svh on the include path and the phy model beside.
 */
`timescale 1ns/100ps
`include "lec_consts.svh"
module tb_top;
    logic ref_clk_i, rst_n_i, cfg_wr_i, cfg_rd_i, ee_load_i, ee_prog_phy_o, ee_prog_phy_vld_o;
    logic phy_enhance_gate_i, retries_zero_i, at_push_i, at_eop_i, at_empty_i, at_tx_done_i;
    logic at_tx_start_o, at_underrun_o, at_sf_mode_o, link_req_i, link_drive_o, give;
    logic prio_arb_en_o, accel_en_o;
    logic [7:0] cfg_addr_i;
    logic [3:0] cfg_be_i;
    logic [31:0] cfg_wdata_i, cfg_rdata_o, ee_data_i, m_reg, lf;
    logic [1:0] phy_ctl_i;
    int n_errors, check_count, cyc, d_off, d_on;
    ////////////////////////////////////////////////////////////////////
    lec_top i_lec_top (.*);
    lec_phy_model i_lec_phy_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .give_i(give),
        .phy_ctl_o(phy_ctl_i));
    // 125 MHz
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    // hang guard, far above the few thousand cycles used
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, e, s);
        end
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // one write pulse; model keeps only writable lanes' bits
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] bm;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & 32'h0000_3086;
        @(posedge ref_clk_i);
        cfg_wr_i <= 1'b1;
        cfg_addr_i <= a;
        cfg_be_i <= be;
        cfg_wdata_i <= d;
        @(posedge ref_clk_i);
        cfg_wr_i <= 1'b0;
        if (a == 8'hF4) m_reg = (m_reg & ~bm) | (d & bm);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        cfg_rd_i <= 1'b1;
        cfg_addr_i <= a;
        @(posedge ref_clk_i);
        cfg_rd_i <= 1'b0;
        @(negedge ref_clk_i);
        chk("cfg_rdata", e, cfg_rdata_o);
    endtask
    task automatic fld(input logic [1:0] c);
        wr(8'hF4, 4'h2, {18'h0, c, 12'h0});
    endtask
    // n quadlets back to back, eop on the last if asked
    task automatic push(input int n, input logic eop);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk_i);
            at_push_i <= 1'b1;
            at_eop_i <= eop && (i == n - 1);
        end
        @(posedge ref_clk_i);
        at_push_i <= 1'b0;
        at_eop_i <= 1'b0;
    endtask
    task automatic see_start(input logic e);
        logic s;
        s = 1'b0;
        repeat (6) @(negedge ref_clk_i) s |= at_tx_start_o;
        chk("tx_start", {31'h0, e}, {31'h0, s});
    endtask
    // n plain quadlets, then the eop quadlet if no start was due
    task automatic pkt(input int n, input logic e);
        push(n, 1'b0);
        see_start(e);
        if (!e) begin
            push(1, 1'b1);
            see_start(1'b1);
        end
        @(posedge ref_clk_i);
        at_tx_done_i <= 1'b1;
        @(posedge ref_clk_i);
        at_tx_done_i <= 1'b0;
    endtask
    task automatic thr(input logic [1:0] c, input int q);
        fld(c);
        push(q - 1, 1'b0);
        see_start(1'b0);
        pkt(1, 1'b1);
    endtask
    task automatic phy_lat(output int d);
        @(posedge ref_clk_i);
        give <= 1'b1;
        link_req_i <= 1'b1;
        d = 0;
        while (link_drive_o !== 1'b1 && d < 10) begin
            @(negedge ref_clk_i);
            d++;
        end
        @(posedge ref_clk_i);
        give <= 1'b0;
        link_req_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        {cfg_wr_i, cfg_rd_i, ee_load_i, phy_enhance_gate_i, retries_zero_i} = 5'h0;
        {at_push_i, at_eop_i, at_empty_i, at_tx_done_i, link_req_i, give} = 6'h0;
        {cfg_addr_i, cfg_be_i, cfg_wdata_i, ee_data_i} = 76'h0;
        rst_n_i = 1'b0;
        m_reg = 32'h0000_1000;
        lf = 32'h5C50;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rdc(8'hF4, m_reg);
        wr(8'hF4, 4'hF, 32'hFFFF_FFFF);
        rdc(8'hF4, m_reg);
        wr(8'hF0, 4'hF, 32'h0);
        rdc(8'hF0, 32'h0);
        for (int i = 0; i < 8; i++) begin
            lf = nxt(lf);
            wr(8'hF4, lf[11:8], lf);
            rdc(8'hF4, m_reg);
        end
        // eeprom image with writable bits and bit 6 redirect
        lf = nxt(lf);
        @(posedge ref_clk_i);
        ee_load_i <= 1'b1;
        ee_data_i <= lf | 32'h40;
        @(posedge ref_clk_i);
        ee_load_i <= 1'b0;
        m_reg = lf & 32'h0000_3086;
        @(negedge ref_clk_i);
        chk("ee_prog_phy", 32'h1, {31'h0, ee_prog_phy_o});
        chk("ee_prog_phy_vld", 32'h1, {31'h0, ee_prog_phy_vld_o});
        rdc(8'hF4, m_reg);
        wr(8'hF4, 4'hF, 32'h0000_1086);
        for (int g = 0; g < 2; g++) begin
            @(posedge ref_clk_i);
            phy_enhance_gate_i <= g[0];
            repeat (3) @(negedge ref_clk_i);
            chk("prio_arb_en", g, {31'h0, prio_arb_en_o});
            chk("accel_en", g, {31'h0, accel_en_o});
        end
        @(posedge ref_clk_i);
        phy_enhance_gate_i <= 1'b0;
        phy_lat(d_off);
        @(posedge ref_clk_i);
        phy_enhance_gate_i <= 1'b1;
        phy_lat(d_on);
        chk("turnaround", d_off + 1, d_on);
        thr(2'h1, `LEC_THR_1P7K_BYTES / 4);
        thr(2'h2, `LEC_THR_1K_BYTES / 4);
        thr(2'h3, `LEC_THR_512_BYTES / 4);
        pkt(2, 1'b0);
        fld(2'h0);
        pkt(520, 1'b0);
        fld(2'h3);
        retries_zero_i <= 1'b1;
        pkt(130, 1'b0);
        retries_zero_i <= 1'b0;
        phy_enhance_gate_i <= 1'b0;
        pkt(130, 1'b0);
        phy_enhance_gate_i <= 1'b1;
        // underrun mid-packet, then the refetched packet waits for eop
        push(128, 1'b0);
        see_start(1'b1);
        @(posedge ref_clk_i);
        at_empty_i <= 1'b1;
        @(posedge ref_clk_i);
        at_empty_i <= 1'b0;
        @(negedge ref_clk_i);
        chk("underrun", 32'h1, {31'h0, at_underrun_o});
        @(negedge ref_clk_i);
        chk("sf_mode", 32'h1, {31'h0, at_sf_mode_o});
        pkt(128, 1'b0);
        repeat (2) @(negedge ref_clk_i);
        chk("sf_mode", 32'h0, {31'h0, at_sf_mode_o});
        wrap_up();
    end
endmodule
